// ===== core/ufi_top.sv
// FIFO control and interrupt priority logic of a serial port, Avalon-MM slave
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
module ufi_top #(
	parameter int DEPTH = ufi_pkg::DEPTH
) (
	input wire logic clk_sys_i, // System clock, 20 MHz
	input wire logic sys_rst_i, // Synchronous reset, active high
	input wire logic [ufi_pkg::ADDR_W-1:0] avs_address_i, // Byte address
	input wire logic avs_read_i, // Read request
	input wire logic avs_write_i, // Write request
	input wire logic [ufi_pkg::DATA_W-1:0] avs_writedata_i, // Write data
	input wire logic [3:0] avs_byteenable_i, // Byte enables
	output logic [ufi_pkg::DATA_W-1:0] avs_readdata_o, // Read data
	output logic avs_waitrequest_o, // Stall, high while idle
	input wire logic rx_push_i, // Byte from receive shift register
	input wire logic [ufi_pkg::BYTE_W-1:0] rx_byte_i, // Received byte
	input wire logic [ufi_pkg::ERR_W-1:0] rx_err_i, // Overrun, parity, framing, break
	input wire logic char_tick_i, // One pulse per character time
	input wire logic [ufi_pkg::ERR_W-1:0] modem_delta_i, // Modem line change pulses
	input wire logic tx_pop_i, // Transmitter takes a byte
	output logic [ufi_pkg::BYTE_W-1:0] tx_byte_o, // Head of transmit FIFO
	output logic tx_valid_o, // Transmit FIFO holds a byte
	output logic irq_o // Interrupt request, active high
);
	import ufi_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	ufi_bus_t bus_st_ff, nxt_bus_st;
	logic wait_ff, nxt_wait;
	logic [DATA_W-1:0] rdata_ff, nxt_rdata;
	logic fifo_en_ff, nxt_fifo_en;
	logic [1:0] trig_sel_ff, nxt_trig_sel;
	logic [IE_W-1:0] int_en_ff, nxt_int_en;
	logic [MC_W-1:0] modem_ctl_ff, nxt_modem_ctl;
	logic [ERR_W-1:0] line_err_ff, nxt_line_err;
	logic [ERR_W-1:0] modem_delta_ff, nxt_modem_delta;
	logic [2:0] to_cnt_ff, nxt_to_cnt;
	logic thre_pend_ff, nxt_thre_pend;
	logic tx_empty_q_ff, nxt_tx_empty_q;
	logic irq_ff, nxt_irq;
	logic tx_valid_ff, nxt_tx_valid;

	logic acc, wr_acc, rd_acc, fc_wr;
	logic [1:0] flush, push_ok, pop_ok;
	logic [BYTE_W-1:0] push_data [2];
	logic [BYTE_W-1:0] head [2];
	logic [CW-1:0] rx_cnt, tx_cnt, cap, trig_level;
	logic rx_data_avail, timeout_pend, thre_set, any_pend;
	logic [ID_W-1:0] id_now;
	logic [BYTE_W-1:0] ident_now;

	function automatic logic [ID_W-1:0] id_encode(input logic ls, input logic rd,
		input logic to, input logic te, input logic ms);
		logic [ID_W-1:0] code;
		code = ID_NONE;
		if (ls)
			code = ID_LINE;
		else if (rd)
			code = ID_RX_DATA;
		else if (to)
			code = ID_TIMEOUT;
		else if (te)
			code = ID_TX_EMPTY;
		else if (ms)
			code = ID_MODEM;
		return code;
	endfunction

	function automatic logic [4:0] trig_decode(input logic [1:0] sel);
		logic [4:0] lvl;
		unique case (sel)
			2'b00: lvl = TRIG_1;
			2'b01: lvl = TRIG_4;
			2'b10: lvl = TRIG_8;
			2'b11: lvl = TRIG_14;
		endcase
		return lvl;
	endfunction

	assign rx_cnt = g_fifo[0].cnt_ff;
	assign tx_cnt = g_fifo[1].cnt_ff;

	// Bus handshake: one wait cycle, then the answer cycle
	always_comb
	begin
		acc = (bus_st_ff == BUS_ANSWER) && (avs_read_i || avs_write_i);
		wr_acc = acc && avs_write_i && avs_byteenable_i[0];
		rd_acc = acc && avs_read_i;
		fc_wr = wr_acc && (avs_address_i == OFS_IDENT);
		cap = fifo_en_ff ? CW'(DEPTH) : CW'(1);
		trig_level = CW'(trig_decode(trig_sel_ff));
		// A write with the enable bit clear, or any write while disabled, discards both FIFOs
		flush[0] = fc_wr && (!avs_writedata_i[FC_ENABLE] || !fifo_en_ff
			|| avs_writedata_i[FC_RX_FLUSH]);
		flush[1] = fc_wr && (!avs_writedata_i[FC_ENABLE] || !fifo_en_ff
			|| avs_writedata_i[FC_TX_FLUSH]);
		push_ok[0] = rx_push_i && (rx_cnt < cap);
		pop_ok[0] = rd_acc && (avs_address_i == OFS_DATA) && (rx_cnt != '0);
		push_ok[1] = wr_acc && (avs_address_i == OFS_DATA) && (tx_cnt < cap);
		pop_ok[1] = tx_pop_i && (tx_cnt != '0);
		push_data[0] = rx_byte_i;
		push_data[1] = avs_writedata_i[BYTE_W-1:0];
	end

	for (genvar g = 0; g < 2; g++)
	begin : g_fifo
		logic [AW-1:0] wptr_ff, rptr_ff, nxt_wptr, nxt_rptr;
		logic [CW-1:0] cnt_ff, nxt_cnt;

		always_comb
		begin
			nxt_wptr = wptr_ff;
			nxt_rptr = rptr_ff;
			nxt_cnt = cnt_ff;
			// Flush beats a push; the shift registers outside are untouched
			if (flush[g])
			begin
				nxt_wptr = '0;
				nxt_rptr = '0;
				nxt_cnt = '0;
			end
			else
			begin
				if (push_ok[g])
					nxt_wptr = wptr_ff + 1'b1;
				if (pop_ok[g])
					nxt_rptr = rptr_ff + 1'b1;
				if (push_ok[g] && !pop_ok[g])
					nxt_cnt = cnt_ff + 1'b1;
				else if (pop_ok[g] && !push_ok[g])
					nxt_cnt = cnt_ff - 1'b1;
			end
		end

		always_ff @(posedge clk_sys_i)
		begin
			if (sys_rst_i)
			begin
				wptr_ff <= '0;
				rptr_ff <= '0;
				cnt_ff <= '0;
			end
			else
			begin
				wptr_ff <= nxt_wptr;
				rptr_ff <= nxt_rptr;
				cnt_ff <= nxt_cnt;
			end
		end

		ufi_mem #(
			.WIDTH(BYTE_W),
			.DEPTH(DEPTH),
			.AW(AW)
		) u_mem (
			.clk_sys_i(clk_sys_i),
			.we_i(push_ok[g] && !flush[g]),
			.waddr_i(wptr_ff),
			.wdata_i(push_data[g]),
			.raddr_i(nxt_rptr),
			.rd_data_o(head[g])
		);
	end

	// Interrupt sources and priority
	always_comb
	begin
		rx_data_avail = fifo_en_ff ? (rx_cnt >= trig_level) : (rx_cnt != '0);
		timeout_pend = fifo_en_ff && (to_cnt_ff == TIMEOUT_CHARS);
		thre_set = (tx_cnt == '0) && !tx_empty_q_ff;
		id_now = id_encode(int_en_ff[IE_LINE] && (|line_err_ff),
			int_en_ff[IE_RX_DATA] && rx_data_avail,
			int_en_ff[IE_RX_DATA] && timeout_pend,
			int_en_ff[IE_TX_EMPTY] && thre_pend_ff,
			int_en_ff[IE_MODEM] && (|modem_delta_ff));
		any_pend = (id_now != ID_NONE);
		ident_now = {fifo_en_ff, fifo_en_ff, 2'b00, id_now};
	end

	always_comb
	begin
		nxt_bus_st = bus_st_ff;
		nxt_wait = 1'b1;
		nxt_rdata = rdata_ff;
		unique case (bus_st_ff)
			BUS_IDLE:
				if (avs_read_i || avs_write_i)
				begin
					nxt_bus_st = BUS_ANSWER;
					nxt_wait = 1'b0;
					// Answer captured here and held, so it cannot shift mid-access
					nxt_rdata = '0;
					unique case (avs_address_i)
						OFS_DATA: nxt_rdata[BYTE_W-1:0] = head[0];
						OFS_INT_EN: nxt_rdata[IE_W-1:0] = int_en_ff;
						OFS_IDENT: nxt_rdata[BYTE_W-1:0] = ident_now;
						OFS_MODEM_CTL: nxt_rdata[MC_W-1:0] = modem_ctl_ff;
						OFS_LINE_STAT: nxt_rdata[BYTE_W-1:0] = {1'b0, tx_cnt == '0,
							tx_cnt == '0, line_err_ff, rx_cnt != '0};
						OFS_MODEM_STAT: nxt_rdata[ERR_W-1:0] = modem_delta_ff;
						default: nxt_rdata = '0;
					endcase
				end
			BUS_ANSWER:
				nxt_bus_st = BUS_IDLE;
		endcase
	end

	// Register writes and read side effects, all at the accepting edge
	always_comb
	begin
		nxt_fifo_en = fifo_en_ff;
		nxt_trig_sel = trig_sel_ff;
		nxt_int_en = int_en_ff;
		nxt_modem_ctl = modem_ctl_ff;
		if (fc_wr)
		begin
			nxt_fifo_en = avs_writedata_i[FC_ENABLE];
			// Bits 3 to 5 carry no function and are dropped
			if (avs_writedata_i[FC_ENABLE])
				nxt_trig_sel = avs_writedata_i[FC_TRIG_HI:FC_TRIG_LO];
		end
		if (wr_acc && (avs_address_i == OFS_INT_EN))
			nxt_int_en = avs_writedata_i[IE_W-1:0];
		if (wr_acc && (avs_address_i == OFS_MODEM_CTL))
			nxt_modem_ctl = avs_writedata_i[MC_W-1:0];
		// Flags keep updating while masked; a new event beats the read clear
		nxt_line_err = line_err_ff;
		if (rd_acc && (avs_address_i == OFS_LINE_STAT))
			nxt_line_err = '0;
		nxt_line_err = nxt_line_err | rx_err_i;
		nxt_line_err[0] = nxt_line_err[0] | (rx_push_i && !push_ok[0]);
		nxt_modem_delta = modem_delta_ff;
		if (rd_acc && (avs_address_i == OFS_MODEM_STAT))
			nxt_modem_delta = '0;
		nxt_modem_delta = nxt_modem_delta | modem_delta_i;
		nxt_thre_pend = thre_pend_ff;
		if (push_ok[1] || (rd_acc && (avs_address_i == OFS_IDENT)
			&& (rdata_ff[ID_W-1:0] == ID_TX_EMPTY)))
			nxt_thre_pend = 1'b0;
		if (thre_set)
			nxt_thre_pend = 1'b1;
		nxt_tx_empty_q = (tx_cnt == '0);
		// Receive buffer read or new byte restarts the idle count
		if (!fifo_en_ff || (rx_cnt == '0) || rx_push_i || pop_ok[0] || flush[0])
			nxt_to_cnt = '0;
		else if (char_tick_i && (to_cnt_ff != TIMEOUT_CHARS))
			nxt_to_cnt = to_cnt_ff + 1'b1;
		else
			nxt_to_cnt = to_cnt_ff;
		nxt_irq = any_pend && modem_ctl_ff[MC_IRQ_GATE];
		nxt_tx_valid = (g_fifo[1].nxt_cnt != '0);
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			bus_st_ff <= BUS_IDLE;
			wait_ff <= 1'b1;
			rdata_ff <= '0;
			fifo_en_ff <= 1'b0;
			trig_sel_ff <= '0;
			int_en_ff <= '0;
			modem_ctl_ff <= '0;
			line_err_ff <= '0;
			modem_delta_ff <= '0;
			to_cnt_ff <= '0;
			thre_pend_ff <= 1'b0;
			tx_empty_q_ff <= 1'b1;
			irq_ff <= 1'b0;
			tx_valid_ff <= 1'b0;
		end
		else
		begin
			bus_st_ff <= nxt_bus_st;
			wait_ff <= nxt_wait;
			rdata_ff <= nxt_rdata;
			fifo_en_ff <= nxt_fifo_en;
			trig_sel_ff <= nxt_trig_sel;
			int_en_ff <= nxt_int_en;
			modem_ctl_ff <= nxt_modem_ctl;
			line_err_ff <= nxt_line_err;
			modem_delta_ff <= nxt_modem_delta;
			to_cnt_ff <= nxt_to_cnt;
			thre_pend_ff <= nxt_thre_pend;
			tx_empty_q_ff <= nxt_tx_empty_q;
			irq_ff <= nxt_irq;
			tx_valid_ff <= nxt_tx_valid;
		end
	end

	assign avs_readdata_o = rdata_ff;
	assign avs_waitrequest_o = wait_ff;
	assign irq_o = irq_ff;
	assign tx_valid_o = tx_valid_ff;
	assign tx_byte_o = head[1];

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);

	a_disable_flush: assert property (
		fc_wr && !avs_writedata_i[FC_ENABLE] |=> (rx_cnt == '0) && (tx_cnt == '0))
		else $error("FIFOs not emptied when disabled");
	a_mode_switch: assert property (
		fc_wr && (avs_writedata_i[FC_ENABLE] != fifo_en_ff)
		|=> (rx_cnt == '0) && (tx_cnt == '0) && $changed(fifo_en_ff))
		else $error("Mode switch did not empty FIFOs");
	a_trig_guard: assert property (
		fc_wr && !avs_writedata_i[FC_ENABLE] |=> $stable(trig_sel_ff))
		else $error("Trigger changed without enable bit");
	a_rx_flush: assert property (
		fc_wr && avs_writedata_i[FC_ENABLE] && avs_writedata_i[FC_RX_FLUSH]
		|=> rx_cnt == '0)
		else $error("Receive flush failed");
	a_tx_flush: assert property (
		fc_wr && avs_writedata_i[FC_ENABLE] && avs_writedata_i[FC_TX_FLUSH]
		|=> tx_cnt == '0)
		else $error("Transmit flush failed");
	a_rx_trigger: assert property (
		fifo_en_ff && (rx_cnt >= trig_level) && int_en_ff[IE_RX_DATA]
		&& modem_ctl_ff[MC_IRQ_GATE] |=> irq_o)
		else $error("Trigger level reached without interrupt");
	a_line_first: assert property (
		int_en_ff[IE_LINE] && (|line_err_ff) |-> ident_now[ID_W-1:0] == ID_LINE)
		else $error("Line status not ranked first");
	a_none_flag: assert property (
		(int_en_ff == '0) |-> ident_now[ID_W-1:0] == ID_NONE)
		else $error("Pending shown with all sources masked");
	a_char_timeout: assert property (
		fifo_en_ff && (rx_cnt != '0) && char_tick_i && !rx_push_i && !pop_ok[0]
		&& !flush[0] && (to_cnt_ff == TIMEOUT_CHARS - 3'h1) |=> timeout_pend)
		else $error("Character timeout missed");
	a_tx_clear: assert property (
		push_ok[1] && !thre_set |=> !thre_pend_ff)
		else $error("Transmit empty not cleared by write");
	a_read_frozen: assert property ((bus_st_ff == BUS_ANSWER) |=> $stable(rdata_ff))
		else $error("Read answer changed during the access");

	c_fifo_on: cover property (fc_wr && avs_writedata_i[FC_ENABLE] && !fifo_en_ff);
	c_timeout: cover property (timeout_pend && int_en_ff[IE_RX_DATA]);
	c_irq_rise: cover property ($rose(irq_o));
endmodule

// ===== core/ufi_pkg.sv
// Shared constants and types for the serial port FIFO and interrupt control block
package ufi_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;
	localparam int DEPTH = 16;
	localparam int ERR_W = 4;
	localparam int IE_W = 4;
	localparam int MC_W = 5;
	localparam int ID_W = 4;

	localparam logic [ADDR_W-1:0] OFS_DATA = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_INT_EN = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_IDENT = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_MODEM_CTL = 5'h0c;
	localparam logic [ADDR_W-1:0] OFS_LINE_STAT = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_MODEM_STAT = 5'h14;

	localparam int FC_ENABLE = 0;
	localparam int FC_RX_FLUSH = 1;
	localparam int FC_TX_FLUSH = 2;
	localparam int FC_TRIG_LO = 6;
	localparam int FC_TRIG_HI = 7;

	localparam int IE_RX_DATA = 0;
	localparam int IE_TX_EMPTY = 1;
	localparam int IE_LINE = 2;
	localparam int IE_MODEM = 3;
	localparam int MC_IRQ_GATE = 3;

	localparam logic [ID_W-1:0] ID_NONE = 4'h1;
	localparam logic [ID_W-1:0] ID_LINE = 4'h6;
	localparam logic [ID_W-1:0] ID_RX_DATA = 4'h4;
	localparam logic [ID_W-1:0] ID_TIMEOUT = 4'hc;
	localparam logic [ID_W-1:0] ID_TX_EMPTY = 4'h2;
	localparam logic [ID_W-1:0] ID_MODEM = 4'h0;

	localparam logic [4:0] TRIG_1 = 5'h01;
	localparam logic [4:0] TRIG_4 = 5'h04;
	localparam logic [4:0] TRIG_8 = 5'h08;
	localparam logic [4:0] TRIG_14 = 5'h0e;
	localparam logic [2:0] TIMEOUT_CHARS = 3'h4;

	typedef enum logic {BUS_IDLE, BUS_ANSWER} ufi_bus_t;
endpackage

// ===== core/ufi_mem.sv
// Small byte store with registered read port for one FIFO
`timescale 1ns/10ps
module ufi_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clk_sys_i, // System clock
	input wire logic we_i, // Write strobe
	input wire logic [AW-1:0] waddr_i, // Write address
	input wire logic [WIDTH-1:0] wdata_i, // Write data
	input wire logic [AW-1:0] raddr_i, // Read address for next cycle
	output logic [WIDTH-1:0] rd_data_o // Registered read data
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] nxt_rd_data;

	// Bypass so a byte pushed into an empty store is visible at once
	always_comb
	begin
		nxt_rd_data = mem[raddr_i];
		if (we_i && (waddr_i == raddr_i))
			nxt_rd_data = wdata_i;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (we_i)
			mem[waddr_i] <= wdata_i;
		rd_data_o <= nxt_rd_data;
	end
endmodule

// ===== tb/ufi_link_model.sv
// Behavioural model of the receiver, transmitter and modem lines beside the block
`timescale 1ns/10ps
module ufi_link_model (
	input wire logic clk_sys_i, // System clock
	input wire logic [7:0] tx_byte_i, // Head of transmit FIFO
	input wire logic tx_valid_i, // Transmit FIFO holds a byte
	output logic rx_push_o, // Byte into receive FIFO
	output logic [7:0] rx_byte_o, // Received byte
	output logic [3:0] rx_err_o, // Error pulses with the byte
	output logic char_tick_o, // Character time pulse
	output logic [3:0] modem_delta_o, // Modem change pulses
	output logic tx_pop_o // Transmitter takes the head byte
);
	initial
	begin
		rx_push_o = 1'b0;
		rx_byte_o = 8'h5a;
		rx_err_o = 4'h0;
		char_tick_o = 1'b0;
		modem_delta_o = 4'h0;
		tx_pop_o = 1'b0;
	end

	// One-cycle pulse; byte lane flips afterwards so a stale value never looks valid
	task automatic pulse(input logic p, input logic [7:0] b, input logic [3:0] e,
		input logic t, input logic [3:0] d);
		@(posedge clk_sys_i);
		rx_push_o <= p;
		rx_byte_o <= b;
		rx_err_o <= e;
		char_tick_o <= t;
		modem_delta_o <= d;
		@(posedge clk_sys_i);
		rx_push_o <= 1'b0;
		rx_byte_o <= ~b;
		rx_err_o <= 4'h0;
		char_tick_o <= 1'b0;
		modem_delta_o <= 4'h0;
	endtask

	// Head register lags a write or pop, so let two edges pass first
	task automatic pop(output logic [7:0] b, output logic v);
		repeat (2) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		b = tx_byte_i;
		v = tx_valid_i;
		@(posedge clk_sys_i);
		tx_pop_o <= v;
		@(posedge clk_sys_i);
		tx_pop_o <= 1'b0;
	endtask
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the FIFO control and interrupt block
`timescale 1ns/10ps
module tb_top;
	import ufi_pkg::*;
	typedef struct {logic [31:0] exp; logic [31:0] mask; logic [4:0] addr;} ufi_note_t;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [ADDR_W-1:0] avs_address_i = '0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [DATA_W-1:0] avs_writedata_i = '0;
	logic [3:0] avs_byteenable_i = 4'hf;
	logic [DATA_W-1:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic rx_push_i;
	logic [7:0] rx_byte_i;
	logic [3:0] rx_err_i;
	logic char_tick_i;
	logic [3:0] modem_delta_i;
	logic tx_pop_i;
	logic [7:0] tx_byte_o;
	logic tx_valid_o;
	logic irq_o;
	int err_count = 0;
	int samples_checked = 0;
	int trig[4] = '{TRIG_1, TRIG_4, TRIG_8, TRIG_14};
	logic [31:0] rnd = 32'h45882d0d;
	logic [7:0] tb_byte;
	logic tb_valid;
	ufi_note_t cur;
	ufi_note_t notes[$];
	logic [7:0] bq[$];
	logic [7:0] tq[$];

	always #25 clk_sys_i = ~clk_sys_i;

	ufi_top #(.DEPTH(16)) i_dut (
		.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.rx_push_i(rx_push_i), .rx_byte_i(rx_byte_i), .rx_err_i(rx_err_i),
		.char_tick_i(char_tick_i), .modem_delta_i(modem_delta_i), .tx_pop_i(tx_pop_i),
		.tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o), .irq_o(irq_o));

	ufi_link_model i_link (
		.clk_sys_i(clk_sys_i), .tx_byte_i(tx_byte_o), .tx_valid_i(tx_valid_o),
		.rx_push_o(rx_push_i), .rx_byte_o(rx_byte_i), .rx_err_o(rx_err_i),
		.char_tick_o(char_tick_i), .modem_delta_o(modem_delta_i), .tx_pop_o(tx_pop_i));

	function automatic logic [31:0] lfsr_step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e)
		begin
			err_count++;
			$display("unexpected %s expected %h seen %h", w, e, s);
		end
	endtask

	// Request held until the rising edge that samples waitrequest low
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_byteenable_i <= be;
		avs_read_i <= !w;
		avs_write_i <= w;
		do
		begin
			@(posedge clk_sys_i);
			n++;
		end
		while (avs_waitrequest_o !== 1'b0 && n < 20);
		if (n >= 20)
		begin
			err_count++;
			report_and_stop;
		end
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
		notes.push_back('{e, m, a});
		bus(1'b0, a, 32'h0, 4'hf);
	endtask

	task automatic put(input logic [3:0] e);
		rnd = lfsr_step(rnd);
		bq.push_back(rnd[7:0]);
		i_link.pulse(1'b1, rnd[7:0], e, 1'b0, 4'h0);
	endtask

	// Read answers are taken at the edge that samples waitrequest low
	always @(posedge clk_sys_i)
	begin
		if (avs_read_i && avs_waitrequest_o === 1'b0 && notes.size() > 0)
		begin
			cur = notes.pop_front();
			chk($sformatf("read %h", cur.addr), cur.exp, avs_readdata_o & cur.mask);
		end
	end

	initial
	begin
		repeat (6) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		rd(OFS_IDENT, 32'h01, 32'hff);
		rd(OFS_INT_EN, 32'h00, 32'hff);
		rd(5'h18, 32'h00, 32'hffffffff);
		bus(1'b1, OFS_INT_EN, 32'h0f, 4'h0);
		rd(OFS_INT_EN, 32'h00, 32'hff);
		wr(OFS_INT_EN, 32'hff);
		rd(OFS_INT_EN, 32'h0f, 32'hff);
		wr(OFS_INT_EN, 32'h01);
		for (int t = 0; t < 4; t++)
		begin
			wr(OFS_IDENT, {24'h0, t[1:0], 6'h3f});
			wr(OFS_MODEM_CTL, 32'h08);
			repeat (trig[t] - 1) put(4'h0);
			rd(OFS_IDENT, 32'hc1, 32'hff);
			put(4'h0);
			rd(OFS_IDENT, 32'hc4, 32'hff);
			@(negedge clk_sys_i);
			chk("irq at trigger", 32'h1, {31'h0, irq_o});
			wr(OFS_MODEM_CTL, 32'h00);
			// Gate lands at the accepting edge, the registered request one edge later
			repeat (2) @(negedge clk_sys_i);
			chk("irq gated", 32'h0, {31'h0, irq_o});
			repeat (trig[t]) rd(OFS_DATA, bq.pop_front(), 32'hff);
			rd(OFS_IDENT, 32'hc1, 32'hff);
		end
		wr(OFS_IDENT, 32'h41);
		put(4'h0);
		repeat (3) i_link.pulse(1'b0, 8'h00, 4'h0, 1'b1, 4'h0);
		rd(OFS_IDENT, 32'hc1, 32'hff);
		i_link.pulse(1'b0, 8'h00, 4'h0, 1'b1, 4'h0);
		rd(OFS_IDENT, 32'hcc, 32'hff);
		rd(OFS_DATA, bq.pop_front(), 32'hff);
		rd(OFS_IDENT, 32'hc1, 32'hff);
		wr(OFS_INT_EN, 32'h0f);
		wr(OFS_IDENT, 32'h01);
		i_link.pulse(1'b0, 8'h00, 4'h0, 1'b0, 4'h1);
		put(4'h2);
		rd(OFS_IDENT, 32'hc6, 32'hff);
		rd(OFS_LINE_STAT, 32'h04, 32'h1e);
		rd(OFS_IDENT, 32'hc4, 32'hff);
		rd(OFS_DATA, bq.pop_front(), 32'hff);
		rd(OFS_IDENT, 32'hc0, 32'hff);
		rd(OFS_MODEM_STAT, 32'h01, 32'h0f);
		rd(OFS_IDENT, 32'hc1, 32'hff);
		wr(OFS_INT_EN, 32'h00);
		put(4'h8);
		rd(OFS_IDENT, 32'hc1, 32'hff);
		rd(OFS_LINE_STAT, 32'h11, 32'h1f);
		rd(OFS_DATA, bq.pop_front(), 32'hff);
		wr(OFS_INT_EN, 32'h02);
		repeat (2)
		begin
			rnd = lfsr_step(rnd);
			tq.push_back(rnd[7:0]);
			wr(OFS_DATA, {24'h0, rnd[7:0]});
		end
		repeat (2)
		begin
			i_link.pop(tb_byte, tb_valid);
			chk("tx byte", {24'h0, tq.pop_front()}, {24'h0, tb_byte});
		end
		rd(OFS_IDENT, 32'hc2, 32'hff);
		rd(OFS_IDENT, 32'hc1, 32'hff);
		wr(OFS_DATA, 32'h3c);
		wr(OFS_IDENT, 32'h05);
		i_link.pop(tb_byte, tb_valid);
		chk("tx valid after flush", 32'h0, {31'h0, tb_valid});
		wr(OFS_DATA, 32'hc3);
		rd(OFS_IDENT, 32'hc1, 32'hff);
		wr(OFS_INT_EN, 32'h01);
		put(4'h0);
		put(4'h0);
		wr(OFS_IDENT, 32'h03);
		bq.delete();
		rd(OFS_LINE_STAT, 32'h00, 32'h01);
		put(4'h0);
		wr(OFS_IDENT, 32'h01);
		rd(OFS_DATA, bq.pop_front(), 32'hff);
		put(4'h0);
		put(4'h0);
		wr(OFS_IDENT, 32'hc0);
		bq.delete();
		rd(OFS_LINE_STAT, 32'h00, 32'h01);
		put(4'h0);
		rd(OFS_IDENT, 32'h04, 32'hff);
		wr(OFS_IDENT, 32'h01);
		bq.delete();
		rd(OFS_LINE_STAT, 32'h00, 32'h01);
		rd(OFS_IDENT, 32'hc1, 32'hff);
		report_and_stop;
	end
endmodule
